// >>> rsc_debounce.sv
// Contact synchroniser and debouncer
`timescale 1ns/1ps
`default_nettype none
module rsc_debounce
  import rsc_pkg::*;
#(
  parameter int CYCLES = DEB_CYCLES_DEF
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // Contact
  input  wire logic raw,
  output var  logic db
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic          s1_reg, s2_reg, db_reg, db_next;
  logic [CW-1:0] cnt_reg, cnt_next;

  always_comb begin
    db_next  = db_reg;
    cnt_next = '0;
    if (s2_reg != db_reg) begin
      cnt_next = cnt_reg + CW'(1);
      if (cnt_reg == LAST) begin
        db_next  = s2_reg;
        cnt_next = '0;
      end
    end
  end

  // Open contact reads high, so idle is one
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s1_reg  <= 1'b1;
      s2_reg  <= 1'b1;
      db_reg  <= 1'b1;
      cnt_reg <= '0;
    end else begin
      s1_reg  <= raw;
      s2_reg  <= s1_reg;
      db_reg  <= db_next;
      cnt_reg <= cnt_next;
    end
  end
  assign db = db_reg;

  a_deb_stable: assert property (@(posedge clk) disable iff (!rst_b)
    !$stable(db_reg) |-> $past(cnt_reg) == LAST)
    else $error("debounced contact moved before hold time");

endmodule : rsc_debounce
`default_nettype wire

// >>> rsc_irq.sv
// Sticky event status, mask and interrupt level
`timescale 1ns/1ps
`default_nettype none
module rsc_irq
  import rsc_pkg::*;
#(
  parameter int N = N_EV
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_b,
  // Events and register writes
  input  wire logic [N-1:0] ev,
  input  wire logic         wr_stat,
  input  wire logic         wr_mask,
  input  wire logic [N-1:0] wdata,
  // State
  output var  logic [N-1:0] stat,
  output var  logic [N-1:0] mask,
  output var  logic         irq
);
  logic [N-1:0] stat_reg, stat_next, mask_reg, mask_next;
  logic         irq_reg, irq_next;

  // Set wins over a write-one clear in the same cycle
  always_comb begin
    stat_next = stat_reg;
    if (wr_stat) stat_next = stat_next & ~wdata;
    stat_next = stat_next | ev;
    mask_next = wr_mask ? wdata : mask_reg;
    irq_next  = |(stat_next & mask_next);
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      stat_reg <= '0;
      mask_reg <= N'(IMASK_RST);
      irq_reg  <= 1'b0;
    end else begin
      stat_reg <= stat_next;
      mask_reg <= mask_next;
      irq_reg  <= irq_next;
    end
  end
  assign stat = stat_reg;
  assign mask = mask_reg;
  assign irq  = irq_reg;

  a_irq_level: assert property (@(posedge clk) disable iff (!rst_b)
    irq_reg == |(stat_reg & mask_reg))
    else $error("interrupt level disagrees with status and mask");

  a_ev_sticky: assert property (@(posedge clk) disable iff (!rst_b)
    ev[0] |=> stat_reg[0])
    else $error("event lost from status");

endmodule : rsc_irq
`default_nettype wire

// >>> rsc_partner.sv
// Model of the two waveguide switches driven by the controller
`timescale 1ns/1ps
`default_nettype none
module rsc_partner (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // Drive and start position
  input  wire logic sel_tx,
  input  wire logic sel_rx,
  input  wire logic start_pos,
  // Position feedback
  output var  logic tx_pos,
  output var  logic rx_pos
);
  int up;
  //////////////////////////////////////////////////////////////////////////
  // Parked at the start position while reset holds the drive at zero
  always @(posedge clk) begin
    if (!rst_b) begin
      up <= 0;
      tx_pos <= start_pos;
      rx_pos <= start_pos;
    end else if (up < 3) begin
      up <= up + 1;
    end else begin
      tx_pos <= sel_tx;
      rx_pos <= sel_rx;
    end
  end
endmodule : rsc_partner
`default_nettype wire

// >>> rsc_pkg.sv
// Constants and types for the redundancy stream switch control
package rsc_pkg;

  // Timing
  localparam int CLK_PERIOD_NS  = 8;
  localparam int DEB_TIME_US    = 10000;
  localparam int HOLD_TIME_US   = 50000;
  localparam int DEB_CYCLES_DEF =
    (DEB_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYCLES_DEF =
    (HOLD_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register offsets
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_REQ   = 8'h01;
  localparam logic [7:0] OFS_STATE = 8'h02;
  localparam logic [7:0] OFS_ISTAT = 8'h03;
  localparam logic [7:0] OFS_IMASK = 8'h04;

  // Field positions and reset values
  localparam int         CTRL_HOT1 = 0;
  localparam int         CTRL_HOT2 = 1;
  localparam int         CTRL_HP   = 2;
  localparam logic [2:0] CTRL_RST  = 3'h3;
  localparam int         REQ_U1    = 0;
  localparam int         REQ_U2    = 1;
  localparam int         EV_SWITCH = 0;
  localparam int         EV_ALM1   = 1;
  localparam int         EV_ALM2   = 2;
  localparam int         EV_REMOTE = 3;
  localparam int         N_EV      = 4;
  localparam logic [3:0] IMASK_RST = 4'h0;

  // Contact order in the debounced vector
  localparam int CT_REM  = 0;
  localparam int CT_MAN  = 1;
  localparam int CT_STR2 = 2;

  typedef enum logic [2:0] {
    RSC_INIT = 3'b001,
    RSC_RUN  = 3'b010,
    RSC_HOLD = 3'b100
  } rsc_state_t;

endpackage : rsc_pkg

// >>> rsc_switch_ctrl.sv
// Stream selection and amplifier control for a one-for-one pair
//
// Local design decisions: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Operation
// - After reset the selection is taken from the present switch position.
// - In automatic mode an alarm on the on-line stream moves to the other.
// - Transmit and receive switches always go to the same stream together.
// - Without the remote contact the block runs automatic, ignoring contacts.
// - An on-line request from either serial port or the register port is obeyed outside remote manual.
// - A grounded remote-enable contact hands control to the other contacts.
// - Under remote, grounded mode contact is manual, open is automatic.
// - In remote manual, grounded stream contact is stream 2, open stream 1.
// - In remote manual the contact stream holds whatever the alarms say.
// - Hot standby keeps both amplifiers on.
// - Warm standby powers only the on-line unit's amplifier unless high power is set.
// - A high-power system keeps the amplifier stage on in both modes.
// - Units see the controller present so their faults stay clearable.
module rsc_switch_ctrl
  import rsc_pkg::*;
#(
  parameter int DEB_CYCLES  = DEB_CYCLES_DEF,
  parameter int HOLD_CYCLES = HOLD_CYCLES_DEF
) (
  // Clock and reset
  input  wire logic       MCLK,
  input  wire logic       RST_B,
  // Register port
  input  wire logic [7:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output var  logic [7:0] RDATA,
  // Serial on-line requests, index 0 unit1 port, 1 unit2 port
  input  wire logic [1:0] REQ_VALID,
  input  wire logic [1:0] REQ_UNIT,
  // Unit alarms
  input  wire logic       ALARM_1,
  input  wire logic       ALARM_2,
  // Switch position feedback, one is stream 2
  input  wire logic       TX_SW_POS,
  input  wire logic       RX_SW_POS,
  // Contact closures, grounded is low
  input  wire logic       REM_EN_B,
  input  wire logic       MODE_MAN_B,
  input  wire logic       STREAM2_B,
  // Switch drive, one is stream 2
  output var  logic       SW_TX_SEL,
  output var  logic       SW_RX_SEL,
  // Amplifier control
  output var  logic       PA_ON_1,
  output var  logic       PA_ON_2,
  output var  logic       HPA_ON,
  // Unit presence and interrupt
  output var  logic       CTRL_PRESENT,
  output var  logic       IRQ
);

  localparam int HW = $clog2(HOLD_CYCLES + 1);
  localparam logic [HW-1:0] HOLD_LAST = HW'(HOLD_CYCLES - 1);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction : hit

  //////////////////////////////////////////////////////////////////////////////
  // Contacts

  logic [2:0] raw_b, db_b;
  assign raw_b[CT_REM]  = REM_EN_B;
  assign raw_b[CT_MAN]  = MODE_MAN_B;
  assign raw_b[CT_STR2] = STREAM2_B;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_deb
      rsc_debounce #(.CYCLES(DEB_CYCLES)) u_deb (
        .clk   (MCLK),
        .rst_b (RST_B),
        .raw   (raw_b[gi]),
        .db    (db_b[gi])
      );
    end
  endgenerate

  logic remote, man_sel, contact_s2;
  assign remote     = ~db_b[CT_REM];
  assign man_sel    = remote & ~db_b[CT_MAN];
  assign contact_s2 = ~db_b[CT_STR2];

  //////////////////////////////////////////////////////////////////////////////
  // Register port

  logic [2:0] ctrl_reg, ctrl_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [3:0] istat, imask;
  logic       wr_ctrl, wr_req, wr_istat, wr_imask;

  assign wr_ctrl  = WR & hit(ADDR, OFS_CTRL);
  assign wr_req   = WR & hit(ADDR, OFS_REQ);
  assign wr_istat = WR & hit(ADDR, OFS_ISTAT);
  assign wr_imask = WR & hit(ADDR, OFS_IMASK);

  //////////////////////////////////////////////////////////////////////////////
  // Selection state

  rsc_state_t    state_reg, state_next;
  logic          online_reg, online_next;
  logic          pend_v_reg, pend_v_next;
  logic          pend_u_reg, pend_u_next;
  logic [HW-1:0] hold_reg, hold_next;
  logic          alarm_on, target, switched;
  logic [1:0]    alm_q_reg;
  logic          rem_q_reg;
  logic [3:0]    ev;

  // Alarm from whichever stream is on-line
  assign alarm_on = online_reg ? ALARM_2 : ALARM_1;

  always_comb begin
    state_next  = state_reg;
    online_next = online_reg;
    pend_v_next = pend_v_reg;
    pend_u_next = pend_u_reg;
    hold_next   = hold_reg;
    target      = online_reg;
    switched    = 1'b0;
    unique case (state_reg)
      RSC_INIT: begin
        // Resume where the switches stand, never a fixed stream
        online_next = TX_SW_POS;
        state_next  = RSC_RUN;
      end
      RSC_RUN: begin
        if (man_sel) begin
          target = contact_s2;
        end else if (pend_v_reg) begin
          target = pend_u_reg;
        end else if (alarm_on) begin
          target = ~online_reg;
        end
        pend_v_next = 1'b0;
        if (target != online_reg) begin
          online_next = target;
          switched    = 1'b1;
          hold_next   = HOLD_LAST;
          state_next  = RSC_HOLD;
        end
      end
      RSC_HOLD: begin
        // Settle time delays each ping-pong move of a double alarm until the count runs out
        if (hold_reg == '0) begin
          state_next = RSC_RUN;
        end else begin
          hold_next = hold_reg - HW'(1);
        end
      end
    endcase
    // New requests win over consumption; dropped under remote manual
    if (man_sel) begin
      pend_v_next = 1'b0;
    end else begin
      if (wr_req && (WDATA[REQ_U1] ^ WDATA[REQ_U2])) begin
        pend_v_next = 1'b1;
        pend_u_next = WDATA[REQ_U2];
      end
      for (int i = 0; i < 2; i++) begin
        if (REQ_VALID[i]) begin
          pend_v_next = 1'b1;
          pend_u_next = REQ_UNIT[i];
        end
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      state_reg  <= RSC_INIT;
      online_reg <= 1'b0;
      pend_v_reg <= 1'b0;
      pend_u_reg <= 1'b0;
      hold_reg   <= '0;
      alm_q_reg  <= 2'h0;
      rem_q_reg  <= 1'b0;
    end else begin
      state_reg  <= state_next;
      online_reg <= online_next;
      pend_v_reg <= pend_v_next;
      pend_u_reg <= pend_u_next;
      hold_reg   <= hold_next;
      alm_q_reg  <= {ALARM_2, ALARM_1};
      rem_q_reg  <= remote;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs

  logic sw_tx_reg, sw_rx_reg, pa1_reg, pa2_reg, hpa_reg, pres_reg;
  logic pa1_next, pa2_next, hpa_next;

  always_comb begin
    ctrl_next = wr_ctrl ? WDATA[2:0] : ctrl_reg;
    hpa_next  = ctrl_next[CTRL_HP];
    // Hot keeps both on; warm powers only the on-line unit unless high power is set
    pa1_next  = ctrl_next[CTRL_HOT1] | ~online_next | hpa_next;
    pa2_next  = ctrl_next[CTRL_HOT2] | online_next | hpa_next;
    rdata_next = 8'h00;
    if (RD) begin
      unique case (ADDR)
        OFS_CTRL:  rdata_next = {5'h00, ctrl_reg};
        OFS_STATE: rdata_next = {2'h0, RX_SW_POS, TX_SW_POS, contact_s2,
                                 man_sel, remote, online_reg};
        OFS_ISTAT: rdata_next = {4'h0, istat};
        OFS_IMASK: rdata_next = {4'h0, imask};
        default:   rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      ctrl_reg  <= CTRL_RST;
      rdata_reg <= 8'h00;
      sw_tx_reg <= 1'b0;
      sw_rx_reg <= 1'b0;
      pa1_reg   <= 1'b0;
      pa2_reg   <= 1'b0;
      hpa_reg   <= 1'b0;
      pres_reg  <= 1'b0;
    end else begin
      ctrl_reg  <= ctrl_next;
      rdata_reg <= rdata_next;
      sw_tx_reg <= online_next;
      sw_rx_reg <= online_next;
      pa1_reg   <= pa1_next;
      pa2_reg   <= pa2_next;
      hpa_reg   <= hpa_next;
      pres_reg  <= 1'b1;
    end
  end

  assign RDATA        = rdata_reg;
  assign SW_TX_SEL    = sw_tx_reg;
  assign SW_RX_SEL    = sw_rx_reg;
  assign PA_ON_1      = pa1_reg;
  assign PA_ON_2      = pa2_reg;
  assign HPA_ON       = hpa_reg;
  assign CTRL_PRESENT = pres_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Interrupts

  assign ev[EV_SWITCH] = switched;
  assign ev[EV_ALM1]   = ALARM_1 & ~alm_q_reg[0];
  assign ev[EV_ALM2]   = ALARM_2 & ~alm_q_reg[1];
  assign ev[EV_REMOTE] = remote ^ rem_q_reg;

  rsc_irq #(.N(N_EV)) u_irq (
    .clk     (MCLK),
    .rst_b   (RST_B),
    .ev      (ev),
    .wr_stat (wr_istat),
    .wr_mask (wr_imask),
    .wdata   (WDATA[N_EV-1:0]),
    .stat    (istat),
    .mask    (imask),
    .irq     (IRQ)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  // Sampled RST_B keeps the release edge out of registered checks

  a_init_position: assert property (@(posedge MCLK) disable iff (!RST_B)
    RST_B && state_reg == RSC_INIT |=> online_reg == $past(TX_SW_POS))
    else $error("start selection not taken from switch position");

  a_auto_alarm_move: assert property (@(posedge MCLK) disable iff (!RST_B)
    state_reg == RSC_RUN && !man_sel && !pend_v_reg && alarm_on
    |=> online_reg != $past(online_reg) && state_reg == RSC_HOLD)
    else $error("alarm on on-line stream did not switch");

  a_paths_together: assert property (@(posedge MCLK) disable iff (!RST_B)
    RST_B |=> SW_TX_SEL == SW_RX_SEL && SW_TX_SEL == online_reg)
    else $error("transmit and receive paths differ");

  a_local_automatic: assert property (@(posedge MCLK) disable iff (!RST_B)
    db_b[CT_REM] |-> !man_sel)
    else $error("manual mode without remote contact");

  a_request_obeyed: assert property (@(posedge MCLK) disable iff (!RST_B)
    state_reg == RSC_RUN && pend_v_reg && !man_sel
    |=> online_reg == $past(pend_u_reg))
    else $error("on-line request not obeyed");

  a_remote_manual: assert property (@(posedge MCLK) disable iff (!RST_B)
    !db_b[CT_REM] && !db_b[CT_MAN] |-> man_sel)
    else $error("grounded mode contact did not select manual");

  a_contact_stream: assert property (@(posedge MCLK) disable iff (!RST_B)
    state_reg == RSC_RUN && man_sel |=> online_reg == $past(contact_s2))
    else $error("contact stream not selected");

  a_manual_holds: assert property (@(posedge MCLK) disable iff (!RST_B)
    man_sel && online_reg == contact_s2 && $stable(db_b)
    |=> $stable(online_reg))
    else $error("stream moved under remote manual");

  a_amp_state: assert property (@(posedge MCLK) disable iff (!RST_B)
    RST_B |=> PA_ON_1 == (ctrl_reg[CTRL_HOT1] | ~online_reg | ctrl_reg[CTRL_HP])
    && PA_ON_2 == (ctrl_reg[CTRL_HOT2] | online_reg | ctrl_reg[CTRL_HP]))
    else $error("amplifier state wrong for standby mode");

  a_hot_both_on: assert property (@(posedge MCLK) disable iff (!RST_B)
    RST_B && ctrl_reg[CTRL_HOT1] && ctrl_reg[CTRL_HOT2] && !wr_ctrl
    |=> PA_ON_1 && PA_ON_2)
    else $error("hot standby amplifier off");

  a_high_power: assert property (@(posedge MCLK) disable iff (!RST_B)
    ctrl_reg[CTRL_HP] && !wr_ctrl |=> HPA_ON && PA_ON_1 && PA_ON_2)
    else $error("high-power stage off");

  a_present: assert property (@(posedge MCLK) disable iff (!RST_B)
    RST_B |=> CTRL_PRESENT)
    else $error("presence not shown to units");

  c_auto_switch: cover property (@(posedge MCLK) disable iff (!RST_B)
    switched && !man_sel && !pend_v_reg);
  c_manual_switch: cover property (@(posedge MCLK) disable iff (!RST_B)
    switched && man_sel);
  c_request_switch: cover property (@(posedge MCLK) disable iff (!RST_B)
    switched && pend_v_reg);
  c_irq_raised: cover property (@(posedge MCLK) disable iff (!RST_B)
    $rose(IRQ));
  c_warm_switch: cover property (@(posedge MCLK) disable iff (!RST_B)
    switched && !ctrl_reg[CTRL_HOT1] && !ctrl_reg[CTRL_HOT2]);

endmodule : rsc_switch_ctrl
`default_nettype wire

// >>> rsc_switch_ctrl_bench.sv
// Register and contact level tests of the stream switch control
`timescale 1ns/1ps
`default_nettype none
module rsc_switch_ctrl_bench;
  import rsc_pkg::*;
  localparam int DEB  = 4;
  localparam int HOLD = 3;
  logic       mclk = 1'b0;
  logic       rst_b = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [1:0] req_valid = 2'h0;
  logic [1:0] req_unit = 2'h0;
  logic       alarm_1 = 1'b0;
  logic       alarm_2 = 1'b0;
  logic       rem_en_b = 1'b1;
  logic       mode_man_b = 1'b1;
  logic       stream2_b = 1'b1;
  logic       start_pos = 1'b1;
  logic [7:0] rdata;
  logic       tx_pos;
  logic       rx_pos;
  logic       sw_tx;
  logic       sw_rx;
  logic       pa_1;
  logic       pa_2;
  logic       hpa;
  logic       present;
  logic       irq;
  logic [7:0] d;
  int         n_errors = 0;
  int         checks_done = 0;
  always #4 mclk = ~mclk;
  //////////////////////////////////////////////////////////////////////////
  rsc_switch_ctrl #(.DEB_CYCLES(DEB), .HOLD_CYCLES(HOLD)) i_rsc_switch_ctrl (
    .MCLK(mclk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .REQ_VALID(req_valid), .REQ_UNIT(req_unit),
    .ALARM_1(alarm_1), .ALARM_2(alarm_2), .TX_SW_POS(tx_pos),
    .RX_SW_POS(rx_pos), .REM_EN_B(rem_en_b), .MODE_MAN_B(mode_man_b),
    .STREAM2_B(stream2_b), .SW_TX_SEL(sw_tx), .SW_RX_SEL(sw_rx),
    .PA_ON_1(pa_1), .PA_ON_2(pa_2), .HPA_ON(hpa),
    .CTRL_PRESENT(present), .IRQ(irq)
  );
  rsc_partner i_rsc_partner (
    .clk(mclk), .rst_b(rst_b), .sel_tx(sw_tx), .sel_rx(sw_rx),
    .start_pos(start_pos), .tx_pos(tx_pos), .rx_pos(rx_pos)
  );
  //////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    if (n_errors == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge mclk);
    wr <= 1'b0;
    tick(1);
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask : rd_reg

  // Polls the drive, then lets the hold time run out
  task automatic wait_sel(input logic exp);
    int i;
    i = 0;
    while (sw_tx !== exp && i < 20) begin
      tick(1);
      i++;
    end
    if (sw_tx !== exp) begin
      n_errors++;
      $display("[ERR] %0t stream select timed out", $time);
      finish_test();
    end
    check(sw_rx, exp);
    tick(HOLD + 2);
  endtask : wait_sel

  task automatic pulse_req(input logic [1:0] v, input logic [1:0] u);
    @(posedge mclk);
    req_valid <= v;
    req_unit <= u;
    @(posedge mclk);
    req_valid <= 2'h0;
    #1;
  endtask : pulse_req
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    wait_sel(1'b1);
    check(present, 1'b1);
    check({pa_1, pa_2, hpa}, 3'b110);
    rd_reg(OFS_CTRL, d);
    check(d, {5'h0, CTRL_RST});
    tick(1);
    check(rdata, 8'h00);
    rd_reg(OFS_IMASK, d);
    check(d, {4'h0, IMASK_RST});
    rd_reg(8'h7f, d);
    check(d, 8'h00);
    wr_reg(OFS_STATE, 8'hff);
    rd_reg(OFS_STATE, d);
    check(d, 8'h31);
    // Alarm on the on-line stream; it stays up after the move
    @(posedge mclk);
    alarm_2 <= 1'b1;
    wait_sel(1'b0);
    tick(HOLD + 4);
    check(sw_tx, 1'b0);
    check(irq, 1'b0);
    rd_reg(OFS_ISTAT, d);
    check(d, 8'h05);
    wr_reg(OFS_IMASK, 8'h01);
    check(irq, 1'b1);
    wr_reg(OFS_ISTAT, 8'h05);
    tick(1);
    check(irq, 1'b0);
    @(posedge mclk);
    alarm_2 <= 1'b0;
    // Warm standby, then on-line requests from bus and both ports
    wr_reg(OFS_CTRL, 8'h00);
    check({pa_1, pa_2}, 2'b10);
    wr_reg(OFS_REQ, 8'h02);
    wait_sel(1'b1);
    check({pa_1, pa_2}, 2'b01);
    pulse_req(2'h1, 2'h0);
    wait_sel(1'b0);
    pulse_req(2'h2, 2'h2);
    wait_sel(1'b1);
    // Same cycle on both ports, the second port wins
    pulse_req(2'h3, 2'h1);
    wait_sel(1'b0);
    wr_reg(OFS_CTRL, 8'h04);
    check({pa_1, pa_2, hpa}, 3'b111);
    wr_reg(OFS_CTRL, 8'h03);
    // Mode and stream contacts without remote enable
    @(posedge mclk);
    mode_man_b <= 1'b0;
    stream2_b <= 1'b0;
    tick(DEB + 6);
    check(sw_tx, 1'b0);
    // A grounding shorter than the debounce time is dropped
    @(posedge mclk);
    rem_en_b <= 1'b0;
    repeat (2) @(posedge mclk);
    rem_en_b <= 1'b1;
    tick(DEB + 6);
    rd_reg(OFS_STATE, d);
    check(d[1], 1'b0);
    @(posedge mclk);
    rem_en_b <= 1'b0;
    tick(DEB + 6);
    wait_sel(1'b1);
    rd_reg(OFS_STATE, d);
    check(d[2:1], 2'b11);
    @(posedge mclk);
    alarm_2 <= 1'b1;
    wr_reg(OFS_REQ, 8'h01);
    tick(HOLD + 6);
    check(sw_tx, 1'b1);
    @(posedge mclk);
    stream2_b <= 1'b1;
    tick(DEB + 6);
    wait_sel(1'b0);
    // Open mode contact returns to automatic switching
    @(posedge mclk);
    alarm_2 <= 1'b0;
    mode_man_b <= 1'b1;
    tick(DEB + 6);
    rd_reg(OFS_ISTAT, d);
    check(d[3], 1'b1);
    @(posedge mclk);
    alarm_1 <= 1'b1;
    wait_sel(1'b1);
    finish_test();
  end
endmodule : rsc_switch_ctrl_bench
`default_nettype wire
